// ==== logic/countdown_timer_irq.sv ====
/*
  countdown timer with reload, flag and open-drain interrupt.
  assumes a synchronous byte register port: one write or read strobe per cycle.
*/
`timescale 1ns/100ps
module countdown_timer_irq
  import cdt_pkg::*;
#(
  // system clock rate, not below the oscillator rate
  parameter int CLK_HZ = SYS_HZ
)
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // interrupt pin
  output logic            irq_n_o,
  output logic            irq_n_oe_o,
  // status
  output logic            tick_o
);
  tick_if tk ();

  logic [7:0]  main_ctl;
  logic [7:0]  next_main_ctl;
  logic        irq_en;
  logic        next_irq_en;
  logic        flag;
  logic        next_flag;
  logic [15:0] period;
  logic [15:0] next_period;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  cd_state_t   state;
  cd_state_t   next_state;
  logic        terminal;
  logic [7:0]  next_rdata;
  logic        run;
  logic        reload;
  logic        wr_ctl;
  logic        wr_flag;
  logic        one_shot_done;
  logic        next_one_shot_done;

  tick_prescaler #(.CLK_HZ(CLK_HZ)) u_pre (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .tk     (tk)
  );

  assign run = main_ctl[BIT_COUNT_RUN];
  assign reload = main_ctl[BIT_AUTO_RELOAD];
  assign tk.src_sel = {main_ctl[BIT_SRC_SEL_HI], main_ctl[BIT_SRC_SEL_LO]}; // [RL4]
  assign wr_ctl = wr_i && (addr_i == ADDR_MAIN_CONTROL);
  assign wr_flag = wr_i && (addr_i == ADDR_IRQ_FLAG);

  // =========================================
  // registers
  always_comb
  begin
    next_main_ctl = main_ctl;
    next_irq_en = irq_en;
    next_period = period;
    if (wr_ctl)
    begin
      next_main_ctl = wdata_i;
      if (run)
      begin
        // locked fields keep their previous contents
        next_main_ctl[BIT_SRC_SEL_HI] = main_ctl[BIT_SRC_SEL_HI]; // [RL12] [RL16]
        next_main_ctl[BIT_SRC_SEL_LO] = main_ctl[BIT_SRC_SEL_LO]; // [RL12] [RL16]
        next_main_ctl[BIT_AUTO_RELOAD] = main_ctl[BIT_AUTO_RELOAD]; // [RL12] [RL16]
      end
    end
    if (wr_i && (addr_i == ADDR_IRQ_ENABLE))
      next_irq_en = wdata_i[BIT_CD_IRQ_EN];
    if (wr_i && !run && !reload) // [RL13]
    begin
      if (addr_i == ADDR_COUNT_LOW)
        next_period[7:0] = wdata_i; // [RL5]
      if (addr_i == ADDR_COUNT_HIGH)
        next_period[15:8] = wdata_i; // [RL5]
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      main_ctl <= RST_MAIN_CTL; // [RL1]
      irq_en <= 1'b0; // [RL2]
      period <= RST_COUNT;
    end
    else
    begin
      main_ctl <= next_main_ctl;
      irq_en <= next_irq_en;
      period <= next_period;
    end
  end

  // =========================================
  // countdown engine
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    terminal = 1'b0;
    if (!run) // [RL3]
      next_state = ST_IDLE;
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          next_cnt = period;
          // zero period leaves the timer stopped; a finished one-shot waits
          // for the control register to be written again
          if ((period != 16'h0000) && !one_shot_done) // [RL6]
            next_state = ST_COUNT;
        end
        ST_COUNT:
        begin
          if (tk.tick)
          begin
            next_cnt = cnt - 16'h0001;
            if (cnt == 16'h0001) // [RL7]
            begin
              terminal = 1'b1;
              next_state = reload ? ST_RELOAD : ST_IDLE; // [RL8]
            end
          end
        end
        ST_RELOAD:
        begin
          // reload uses one source tick
          if (tk.tick) // [RL9]
          begin
            next_cnt = period; // [RL8]
            next_state = ST_COUNT;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
    // one-shot: idle after a period without reload until control is written
    next_one_shot_done = one_shot_done;
    if (terminal && !reload)
      next_one_shot_done = 1'b1;
    else if (state == ST_COUNT)
      next_one_shot_done = 1'b0;
    if (!run || wr_ctl)
      next_one_shot_done = 1'b0;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt <= RST_COUNT;
      state <= ST_IDLE;
      one_shot_done <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      state <= next_state;
      one_shot_done <= next_one_shot_done;
    end
  end

  // =========================================
  // flag and read data
  always_comb
  begin
    next_flag = flag;
    if (wr_flag && !wdata_i[BIT_CD_FLAG])
      next_flag = 1'b0; // [RL11]
    if (terminal && irq_en)
      next_flag = 1'b1; // [RL10] [RL15]
    next_rdata = 8'h00;
    if (rd_i)
    begin
      unique case (addr_i)
        ADDR_MAIN_CONTROL: next_rdata = main_ctl;
        ADDR_IRQ_ENABLE:   next_rdata = 8'(irq_en) << BIT_CD_IRQ_EN;
        ADDR_IRQ_FLAG:     next_rdata = 8'(flag) << BIT_CD_FLAG;
        ADDR_COUNT_LOW:    next_rdata = period[7:0];
        ADDR_COUNT_HIGH:   next_rdata = period[15:8];
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      flag <= 1'b0;
      rdata_o <= 8'h00;
    end
    else
    begin
      flag <= next_flag;
      rdata_o <= next_rdata;
    end
  end

  // =========================================
  // open-drain interrupt: drive low while flag is set
  assign irq_n_o = 1'b0; // [RL14]
  assign irq_n_oe_o = flag; // [RL11] [RL14]
  assign tick_o = tk.tick;
endmodule

// ==== inc/cdt_pkg.sv ====
/*
  constants, register map and field layout of the countdown timer block.
  assumes a 50 MHz system clock and a synchronous byte-wide register port.
*/
// What this block does
// RL1: reset: timer, reload off, 32Hz source
// RL2: reset: countdown interrupt enable cleared
// RL3: count only while run bit set
// RL4: select bits pick 32/8/1/0.5 Hz
// RL5: load value from low and high bytes
// RL6: periods 1..65535 valid, zero stops
// RL7: period ends when counter reaches zero
// RL8: auto reload restarts period after terminal count
// RL9: reload costs one extra tick
// RL10: flag set at terminal count when enabled
// RL11: interrupt mirrors flag, cleared by writing zero
// RL12: select and reload writable only when stopped
// RL13: count bytes writable only stopped, no reload
// RL14: interrupt active low open drain
// RL15: flag holds until software clears it
// RL16: locked bits keep value, others update
// RL17: prescaler ticks from 32.768 kHz oscillator
package cdt_pkg;
  // =========================================
  // register map
  localparam logic [7:0] ADDR_MAIN_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_IRQ_ENABLE   = 8'h01;
  localparam logic [7:0] ADDR_IRQ_FLAG     = 8'h02;
  localparam logic [7:0] ADDR_COUNT_LOW    = 8'h18;
  localparam logic [7:0] ADDR_COUNT_HIGH   = 8'h19;
  // =========================================
  // field positions
  localparam int BIT_COUNT_RUN   = 1;
  localparam int BIT_AUTO_RELOAD = 2;
  localparam int BIT_SRC_SEL_LO  = 5;
  localparam int BIT_SRC_SEL_HI  = 6;
  localparam int BIT_CD_IRQ_EN   = 1;
  localparam int BIT_CD_FLAG     = 1;
  // =========================================
  // reset values
  localparam logic [1:0]  RST_SRC_SEL = 2'h0;
  localparam logic [7:0]  RST_MAIN_CTL = 8'h99;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  // =========================================
  // prescaler: oscillator is 32.768 kHz, taps of a 16-bit divider
  localparam int OSC_HZ = 32768;
  localparam int SYS_HZ = 50000000;
  localparam int TAP_32HZ  = 9;
  localparam int TAP_8HZ   = 11;
  localparam int TAP_1HZ   = 14;
  localparam int TAP_HALFHZ = 15;
  typedef enum logic [1:0] {
    SRC_32HZ   = 2'b00,
    SRC_8HZ    = 2'b01,
    SRC_1HZ    = 2'b10,
    SRC_HALFHZ = 2'b11
  } src_sel_t;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_COUNT  = 2'b01,
    ST_RELOAD = 2'b10
  } cd_state_t;
endpackage

// ==== inc/tick_if.sv ====
/*
  carrier for the tick selection between the timer and its prescaler.
  assumes both ends share clk_i.
*/
`timescale 1ns/100ps
interface tick_if;
  logic [1:0] src_sel;
  logic       tick;
  modport timer (output src_sel, input tick);
  modport prescaler (input src_sel, output tick);
endinterface

// ==== logic/tick_prescaler.sv ====
/*
  derives the four timer tick rates from the system clock.
  assumes clk_i at CLK_HZ, not below the oscillator rate; an oscillator enable
  is made by phase accumulation.
*/
`timescale 1ns/100ps
module tick_prescaler
  import cdt_pkg::*;
#(
  // system clock rate
  parameter int CLK_HZ = SYS_HZ
)
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // tick link
  tick_if.prescaler tk
);
  logic [25:0] acc;
  logic [25:0] next_acc;
  logic        osc_en;
  logic [15:0] div;
  logic [15:0] next_div;
  logic [15:0] rise;
  logic        tick_r;
  logic        next_tick;

  // =========================================
  // oscillator enable and divider
  always_comb
  begin
    osc_en = 1'b0;
    next_acc = acc + 26'(OSC_HZ);
    if (next_acc >= 26'(CLK_HZ))
    begin
      next_acc = next_acc - 26'(CLK_HZ);
      osc_en = 1'b1;
    end
    next_div = osc_en ? div + 16'h0001 : div; // [RL17]
    rise = next_div & ~div;
    unique case (src_sel_t'(tk.src_sel))
      SRC_32HZ:   next_tick = osc_en & rise[TAP_32HZ];
      SRC_8HZ:    next_tick = osc_en & rise[TAP_8HZ];
      SRC_1HZ:    next_tick = osc_en & rise[TAP_1HZ];
      SRC_HALFHZ: next_tick = osc_en & rise[TAP_HALFHZ]; // [RL4]
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      acc <= 26'h0000000;
      div <= 16'h0000;
      tick_r <= 1'b0;
    end
    else
    begin
      acc <= next_acc;
      div <= next_div;
      tick_r <= next_tick;
    end
  end

  assign tk.tick = tick_r; // [RL17]
endmodule

// ==== dv/cdt_sva.sv ====
/*
  port checker for countdown_timer_irq.
  assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module cdt_sva
  import cdt_pkg::*;
(
  // design ports
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic       wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       irq_n_o,
  input wire logic       irq_n_oe_o,
  input wire logic       tick_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic mapped;
  assign mapped = addr_i inside {ADDR_MAIN_CONTROL, ADDR_IRQ_ENABLE, ADDR_IRQ_FLAG,
                                 ADDR_COUNT_LOW, ADDR_COUNT_HIGH};
  // ==========================================
  // sequences
  sequence s_clr;
    wr_i && addr_i == ADDR_IRQ_FLAG && !wdata_i[BIT_CD_FLAG] && !tick_o;
  endsequence
  sequence s_rd_en;
    rd_i && addr_i == ADDR_IRQ_ENABLE;
  endsequence
  // ==========================================
  // assertions
  a_pin_low: assert property (irq_n_o == 1'b0)
    else $error("interrupt pin data not low");
  a_oe_reset: assert property ($rose(rstn_i) |-> !irq_n_oe_o)
    else $error("interrupt active after reset");
  a_tick_single: assert property (tick_o |=> !tick_o)
    else $error("tick longer than one cycle");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero when idle");
  a_unmapped_zero: assert property (rd_i && !mapped |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_enable_bits: assert property (s_rd_en |=> (rdata_o & 8'hfd) == 8'h00)
    else $error("enable register unused bits set");
  a_flag_holds: assert property (irq_n_oe_o && !(wr_i && addr_i == ADDR_IRQ_FLAG)
    |=> irq_n_oe_o)
    else $error("interrupt dropped without clear");
  a_flag_clear: assert property (s_clr |=> !irq_n_oe_o)
    else $error("interrupt not released by clear");
  a_set_cause: assert property ($rose(irq_n_oe_o)
    |-> (tick_o || $past(tick_o) || $past(tick_o, 2)))
    else $error("interrupt set without tick");
endmodule
bind countdown_timer_irq cdt_sva u_cdt_sva (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
  .wr_i(wr_i), .wdata_i(wdata_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_n_o(irq_n_o),
  .irq_n_oe_o(irq_n_oe_o), .tick_o(tick_o));

// ==== dv/testbench.sv ====
/*
  self-checking bench for countdown_timer_irq register behaviour.
  assumes the checker is bound to the design by its own file.
*/
`timescale 1ns/100ps
module testbench
  import cdt_pkg::*;
;
  logic       clk_i      = 1'b0;
  logic       rstn_i     = 1'b0;
  logic [7:0] addr_i     = 8'h00;
  logic       wr_i       = 1'b0;
  logic [7:0] wdata_i    = 8'h00;
  logic       rd_i       = 1'b0;
  logic       rd_seen    = 1'b0;
  logic [7:0] rdata_o;
  logic       irq_n_o;
  logic       irq_n_oe_o;
  logic       tick_o;
  logic [7:0] exp_q[$];
  logic [7:0] v;
  logic [7:0] c;
  int         mismatches = 0;
  int         n_compared = 0;
  int         seed       = 69805;
  logic [7:0] exp_v;
  int         ticks;
  int         gap;
  // oscillator enable on every clock: a 32 Hz tick every 1024 cycles
  localparam int CLK_HZ_TB = OSC_HZ;
  always #10 clk_i = ~clk_i;
  countdown_timer_irq #(.CLK_HZ(CLK_HZ_TB)) u_countdown_timer_irq (.clk_i(clk_i),
    .rstn_i(rstn_i), .addr_i(addr_i), .wr_i(wr_i), .wdata_i(wdata_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_n_o(irq_n_o), .irq_n_oe_o(irq_n_oe_o), .tick_o(tick_o));
  // ==========================================
  // bus tasks and result monitor
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    addr_i = a;
    rd_i = 1'b1;
    exp_q.push_back(e);
    @(negedge clk_i);
    rd_i = 1'b0;
  endtask
  task automatic do_reset();
    rstn_i = 1'b0;
    repeat (5) @(negedge clk_i);
    rstn_i = 1'b1;
  endtask
  always @(posedge clk_i) rd_seen <= rd_i;
  always @(negedge clk_i)
    if (rd_seen)
    begin
      exp_v = exp_q.pop_front();
      n_compared++;
      if (rdata_o !== exp_v)
      begin
        mismatches++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, rdata_o, exp_v);
      end
    end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic next_tick();
    @(negedge clk_i);
    while (!tick_o)
      @(negedge clk_i);
  endtask
  task automatic tick_gap(output int g);
    next_tick();
    g = 1;
    @(negedge clk_i);
    while (!tick_o)
    begin
      @(negedge clk_i);
      g++;
    end
  endtask
  task automatic count_ticks(output int t);
    t = 0;
    while (!irq_n_oe_o)
    begin
      @(negedge clk_i);
      t += int'(tick_o);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================
  // tests
  initial
  begin
    // timer tests take about 18k to 31k cycles
    repeat (60000) @(posedge clk_i);
    mismatches++;
    finish_test();
  end
  initial
  begin
    do_reset();
    rd(ADDR_MAIN_CONTROL, RST_MAIN_CTL);
    rd(ADDR_IRQ_ENABLE, 8'h00);
    rd(ADDR_IRQ_FLAG, 8'h00);
    rd(ADDR_COUNT_LOW, 8'h00);
    rd(8'h05, 8'h00);
    $display("test reset values done");
    v = $random(seed);
    c = $random(seed);
    v = v | 8'h01;
    wr(ADDR_COUNT_LOW, v);
    wr(ADDR_COUNT_HIGH, c);
    rd(ADDR_COUNT_LOW, v);
    rd(ADDR_COUNT_HIGH, c);
    wr(ADDR_IRQ_ENABLE, 8'hff);
    rd(ADDR_IRQ_ENABLE, 8'h02);
    wr(ADDR_IRQ_FLAG, 8'hff);
    rd(ADDR_IRQ_FLAG, 8'h00);
    $display("test count and flag done");
    wr(ADDR_MAIN_CONTROL, 8'h02);
    wr(ADDR_MAIN_CONTROL, 8'hfe);
    rd(ADDR_MAIN_CONTROL, 8'h9a);
    wr(ADDR_COUNT_LOW, ~v);
    rd(ADDR_COUNT_LOW, v);
    wr(ADDR_MAIN_CONTROL, 8'h00);
    rd(ADDR_MAIN_CONTROL, 8'h00);
    $display("test run lock done");
    for (int s = 0; s < 4; s++)
    begin
      wr(ADDR_MAIN_CONTROL, {1'b0, s[1:0], 5'h04});
      rd(ADDR_MAIN_CONTROL, {1'b0, s[1:0], 5'h04});
      wr(ADDR_COUNT_HIGH, ~c);
      rd(ADDR_COUNT_HIGH, c);
    end
    wr(ADDR_MAIN_CONTROL, 8'h00);
    wr(ADDR_COUNT_HIGH, ~c);
    rd(ADDR_COUNT_HIGH, ~c);
    $display("test select and reload lock done");
    c = $random(seed);
    v = {6'h00, c[1:0]} | 8'h01;
    wr(ADDR_COUNT_LOW, v);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_IRQ_ENABLE, 8'h02);
    tick_gap(gap);
    check(gap, CLK_HZ_TB / 32);
    wr(ADDR_MAIN_CONTROL, 8'h06);
    count_ticks(ticks);
    check(ticks, v);
    check(irq_n_o, 1'b0);
    wr(ADDR_IRQ_FLAG, 8'h00);
    check(irq_n_oe_o, 1'b0);
    count_ticks(ticks);
    check(ticks, v + 8'h01);
    rd(ADDR_IRQ_FLAG, 8'h02);
    wr(ADDR_MAIN_CONTROL, 8'h00);
    wr(ADDR_MAIN_CONTROL, 8'h00);
    wr(ADDR_IRQ_FLAG, 8'h00);
    repeat (v + 8'h02) next_tick();
    check(irq_n_oe_o, 1'b0);
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_MAIN_CONTROL, 8'h02);
    repeat (2) next_tick();
    check(irq_n_oe_o, 1'b0);
    wr(ADDR_MAIN_CONTROL, 8'h00);
    wr(ADDR_COUNT_LOW, v);
    wr(ADDR_MAIN_CONTROL, 8'h02);
    count_ticks(ticks);
    check(ticks, v);
    wr(ADDR_IRQ_FLAG, 8'h00);
    repeat (v + 8'h02) next_tick();
    check(irq_n_oe_o, 1'b0);
    wr(ADDR_MAIN_CONTROL, 8'h00);
    wr(ADDR_MAIN_CONTROL, 8'h20);
    tick_gap(gap);
    check(gap, CLK_HZ_TB / 8);
    $display("test timer done");
    do_reset();
    rd(ADDR_MAIN_CONTROL, RST_MAIN_CTL);
    rd(ADDR_IRQ_ENABLE, 8'h00);
    $display("test second reset done");
    repeat (2) @(negedge clk_i);
    finish_test();
  end
endmodule
